// ---- dacrm_top.sv ----
/*
  Register map of a single-channel current/voltage output converter behind
  a 24-bit serial frame port: code, control, soft reset and status, with
  readback and daisy-chain shifting on the serial output.
  Assumes the host stops the link clock before raising the load strobe and
  keeps it still for at least four clk_sys cycles after that rising edge.
*/
//
// Function
// - address byte 01 loads the data word into the code register
// - 12-bit build ignores low four bits; 16-bit keeps all sixteen
// - address byte 55 loads the full word into the control register
// - control fields: clear, widen, resistor, enable, rate, step, slew
// - widen bit stretches the chosen voltage range by ten percent
// - resistor bit selects the external current setting resistor
// - outputs stay off until enable; range picks voltage or current
// - slew bit turns rate limiting on; rate and step configure it
// - codes 0-3 select voltage ranges, codes 5-7 current ranges
// - address byte 56 writes the reset register, only bit zero counts
// - reset bit returns all registers and outputs to power-on state
// - after power-on or reset every register holds zero
// - status is read-only; bits fifteen to three read zero
// - status bit two shows a current output fault
// - status bit one shows the output still slewing
// - status bit zero shows core over-temperature
// - address byte 02 picks a register; next frame shifts it out
// - serial out enabled by the request's own strobe, disabled by the next one
`timescale 1ns/1ps
module dacrm_top #(
  parameter int CODE_BITS = 16,
  parameter int SLEW_UNIT = dacrm_pkg::SLEW_UNIT_CYCLES
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic link_clk,
  input wire logic link_data_in,
  input wire logic link_latch,
  output logic serial_out,
  output logic serial_out_oe,
  input wire logic iout_fault_in,
  input wire logic over_temp_in,
  output logic [15:0] dac_level,
  output logic output_on,
  output logic voltage_out_on,
  output logic current_out_on,
  output logic [2:0] range_select,
  output logic range_widen,
  output logic external_resistor_select,
  output logic clear_level_select,
  output logic slew_limit_on,
  output logic [3:0] slew_update_rate,
  output logic [2:0] slew_increment,
  output logic chain_mode_on,
  output logic [15:0] fault_status
);
  import dacrm_pkg::*;

  localparam logic [15:0] CODE_MASK = 16'(16'hFFFF << (16 - CODE_BITS));

  // ---------------- link domain ----------------
  logic [23:0] link_shift;
  logic [23:0] next_link_shift;
  logic [4:0] edge_cnt;
  logic [4:0] next_edge_cnt;
  logic [23:0] out_shift;
  logic [23:0] next_out_shift;
  logic first_pending;
  logic arm_async;
  logic out_bit;
  logic frame_tag;
  logic next_frame_tag;

  // the strobe arms a restart of the edge count at the next frame
  assign arm_async = link_latch | ~nrst;

  always_ff @(posedge link_clk or posedge arm_async) begin
    if (arm_async) begin
      first_pending <= 1'b1;
    end else begin
      first_pending <= 1'b0;
    end
  end

  logic [15:0] rd_word;
  logic [15:0] ctrl;

  always_comb begin
    next_link_shift = {link_shift[22:0], link_data_in};
    next_frame_tag = frame_tag;
    if (first_pending) begin
      next_edge_cnt = 5'h01;
      // each new frame flips the tag, so a strobe with no edges after it
      // cannot make the system side decode the old shift contents again
      next_frame_tag = ~frame_tag;
      // readback word leaves msb first, address byte as zeros
      next_out_shift = {7'h00, rd_word, 1'b0};
    end else begin
      next_edge_cnt = (edge_cnt == EDGE_SAT) ? EDGE_SAT
                                             : edge_cnt + 5'h01;
      next_out_shift = {out_shift[22:0], 1'b0};
    end
  end

  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      link_shift <= '0;
      edge_cnt <= '0;
      out_shift <= '0;
      frame_tag <= 1'b0;
    end else begin
      link_shift <= next_link_shift;
      edge_cnt <= next_edge_cnt;
      out_shift <= next_out_shift;
      frame_tag <= next_frame_tag;
    end
  end

  // data changes on the falling edge so it is valid at the rising one
  always_ff @(negedge link_clk or negedge nrst) begin
    if (!nrst) begin
      out_bit <= 1'b0;
    end else begin
      out_bit <= ctrl[CTL_CHAIN] ? link_shift[FRAME_W-1]
                                 : out_shift[FRAME_W-1];
    end
  end

  assign serial_out = out_bit;

  // ---------------- system domain ----------------
  logic [2:0] sync_in;
  logic [2:0] sync_out;
  logic latch_s;
  logic ifault_s;
  logic otemp_s;

  assign sync_in = {link_latch, iout_fault_in, over_temp_in};

  dacrm_sync #(
    .WIDTH(3)
  ) u_sync (
    .clk(clk_sys),
    .nrst(nrst),
    .din(sync_in),
    .dout(sync_out)
  );

  assign latch_s = sync_out[2];
  assign ifault_s = sync_out[1];
  assign otemp_s = sync_out[0];

  logic latch_q;
  logic [15:0] code;
  logic [1:0] rsel;
  logic read_pend;
  logic out_en;
  logic [15:0] next_code;
  logic [15:0] next_ctrl;
  logic [1:0] next_rsel;
  logic next_read_pend;
  logic next_out_en;
  logic [15:0] next_rd_word;
  logic latch_rise;
  logic frame_ok;
  logic [7:0] frame_addr;
  logic [15:0] frame_data;
  logic slew_busy;
  logic [15:0] read_mux;
  // tag of the last frame the system side has looked at
  logic taken_tag;
  logic next_taken_tag;

  assign latch_rise = latch_s & ~latch_q;
  // link is still at strobe time, so count, tag and word are stable here
  assign frame_ok = (edge_cnt == FRAME_BITS)
    && (frame_tag != taken_tag);
  assign frame_addr = link_shift[ADDR_MSB:ADDR_LSB];
  assign frame_data = link_shift[WORD_W-1:0];

  // status is built from live state only; no write path reaches it
  always_comb begin
    fault_status = REG_RESET;
    fault_status[ST_IFAULT] = ifault_s;
    fault_status[ST_SLEW] = slew_busy;
    fault_status[ST_OTEMP] = otemp_s;
  end

  always_comb begin
    unique case (rsel)
      RD_STATUS: read_mux = fault_status;
      RD_CODE: read_mux = code;
      RD_CTRL: read_mux = ctrl;
      default: read_mux = REG_RESET;
    endcase
  end

  always_comb begin
    next_code = code;
    next_ctrl = ctrl;
    next_rsel = rsel;
    next_read_pend = read_pend;
    next_out_en = out_en;
    next_rd_word = rd_word;
    next_taken_tag = taken_tag;
    // the word is taken one cycle after its select is stored
    if (read_pend) begin
      next_rd_word = read_mux;
      next_read_pend = 1'b0;
    end
    if (latch_rise) begin
      next_taken_tag = frame_tag;
      // every strobe closes a readback window, even a refused frame
      next_out_en = 1'b0;
      if (frame_ok) begin
        unique case (frame_addr)
          ADDR_NOP: begin
          end
          ADDR_CODE: begin
            next_code = frame_data & CODE_MASK;
          end
          ADDR_READ: begin
            next_rsel = frame_data[1:0];
            next_read_pend = 1'b1;
            // the request's own strobe opens the output for the next frame
            next_out_en = 1'b1;
          end
          ADDR_CTRL: begin
            next_ctrl = frame_data;
          end
          ADDR_RST: begin
            if (frame_data[RST_BIT]) begin
              next_code = REG_RESET;
              next_ctrl = REG_RESET;
              next_rsel = RSEL_RESET;
              next_read_pend = 1'b0;
              next_out_en = 1'b0;
              next_rd_word = REG_RESET;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      latch_q <= 1'b0;
      code <= REG_RESET;
      ctrl <= REG_RESET;
      rsel <= RSEL_RESET;
      read_pend <= 1'b0;
      out_en <= 1'b0;
      rd_word <= REG_RESET;
      taken_tag <= 1'b0;
    end else begin
      latch_q <= latch_s;
      taken_tag <= next_taken_tag;
      code <= next_code;
      ctrl <= next_ctrl;
      rsel <= next_rsel;
      read_pend <= next_read_pend;
      out_en <= next_out_en;
      rd_word <= next_rd_word;
    end
  end

  // chain mode keeps the output driven so frames ripple through
  assign serial_out_oe = out_en | ctrl[CTL_CHAIN];

  // ---------------- output control ----------------
  assign clear_level_select = ctrl[CTL_CLR_LVL];
  assign range_widen = ctrl[CTL_WIDEN];
  assign external_resistor_select = ctrl[CTL_EXT_RES];
  assign output_on = ctrl[CTL_OUT_ON];
  assign slew_update_rate = ctrl[CTL_RATE_MSB:CTL_RATE_LSB];
  assign slew_increment = ctrl[CTL_INC_MSB:CTL_INC_LSB];
  assign slew_limit_on = ctrl[CTL_SLEW_ON];
  assign chain_mode_on = ctrl[CTL_CHAIN];
  assign range_select = ctrl[CTL_RANGE_MSB:CTL_RANGE_LSB];

  // voltage below the undefined code, current above it
  assign voltage_out_on = output_on
    && (range_select < RNG_UNDEF);
  assign current_out_on = output_on
    && (range_select > RNG_UNDEF);

  dacrm_slew #(
    .UNIT_CYCLES(SLEW_UNIT)
  ) u_slew (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .target(code),
    .limit_on(slew_limit_on),
    .update_rate(slew_update_rate),
    .increment(slew_increment),
    .level(dac_level),
    .busy(slew_busy)
  );
endmodule // dacrm_top

// ---- dacrm_pkg.sv ----
/*
  Shared constants for the converter register map: frame layout, register
  addresses, control and status field positions, reset values and timing.
  Assumes nothing of its surroundings.
*/
package dacrm_pkg;
  // frame layout
  localparam logic [4:0] FRAME_BITS = 5'h18;
  localparam logic [4:0] EDGE_SAT = 5'h19;
  localparam int FRAME_W = 24;
  localparam int WORD_W = 16;
  localparam int ADDR_LSB = 16;
  localparam int ADDR_MSB = 23;

  // address byte values
  localparam logic [7:0] ADDR_NOP = 8'h00;
  localparam logic [7:0] ADDR_CODE = 8'h01;
  localparam logic [7:0] ADDR_READ = 8'h02;
  localparam logic [7:0] ADDR_CTRL = 8'h55;
  localparam logic [7:0] ADDR_RST = 8'h56;

  // read select values
  localparam logic [1:0] RD_STATUS = 2'h0;
  localparam logic [1:0] RD_CODE = 2'h1;
  localparam logic [1:0] RD_CTRL = 2'h2;

  // control field positions
  localparam int CTL_CLR_LVL = 15;
  localparam int CTL_WIDEN = 14;
  localparam int CTL_EXT_RES = 13;
  localparam int CTL_OUT_ON = 12;
  localparam int CTL_RATE_LSB = 8;
  localparam int CTL_RATE_MSB = 11;
  localparam int CTL_INC_LSB = 5;
  localparam int CTL_INC_MSB = 7;
  localparam int CTL_SLEW_ON = 4;
  localparam int CTL_CHAIN = 3;
  localparam int CTL_RANGE_LSB = 0;
  localparam int CTL_RANGE_MSB = 2;

  // range codes: below the undefined code select voltage, above it current
  localparam logic [2:0] RNG_UNDEF = 3'h4;

  // status and reset bit positions
  localparam int ST_IFAULT = 2;
  localparam int ST_SLEW = 1;
  localparam int ST_OTEMP = 0;
  localparam int RST_BIT = 0;

  // values after reset
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [1:0] RSEL_RESET = 2'h0;

  // slew timing: one update period unit
  localparam int CLK_PERIOD_PS = 5000;
  localparam int SLEW_UNIT_NS = 80;
  localparam int SLEW_UNIT_CYCLES = (SLEW_UNIT_NS * 1000) / CLK_PERIOD_PS;
endpackage

// ---- dacrm_sync.sv ----
/*
  Two flip-flop level synchroniser, WIDTH bits wide.
  Assumes each bit is a slow level; no bus coherence across bits.
*/
`timescale 1ns/1ps
module dacrm_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stage1 <= '0;
      dout <= '0;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule // dacrm_sync

// ---- dacrm_slew.sv ----
/*
  Digital slew limiter: moves the applied level toward the target code by
  a step of 2**increment every UNIT_CYCLES << rate clock cycles.
  Assumes target and settings come from registers on the same clock.
*/
`timescale 1ns/1ps
module dacrm_slew
  import dacrm_pkg::*;
#(
  parameter int UNIT_CYCLES = SLEW_UNIT_CYCLES
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [15:0] target,
  input wire logic limit_on,
  input wire logic [3:0] update_rate,
  input wire logic [2:0] increment,
  output logic [15:0] level,
  output logic busy
);
  logic [23:0] tick;
  logic [23:0] next_tick;
  logic [15:0] next_level;
  logic [23:0] period;
  logic [16:0] step;
  logic [16:0] diff;

  always_comb begin
    period = 24'(UNIT_CYCLES) << update_rate;
    step = 17'h00001 << increment;
    next_tick = tick + 24'h000001;
    next_level = level;
    diff = '0;
    if (!limit_on) begin
      next_level = target;
      next_tick = '0;
    end else if (tick + 24'h000001 >= period) begin
      next_tick = '0;
      if (target > level) begin
        diff = {1'b0, target} - {1'b0, level};
        next_level = (diff <= step) ? target : level + step[15:0];
      end else if (target < level) begin
        diff = {1'b0, level} - {1'b0, target};
        next_level = (diff <= step) ? target : level - step[15:0];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tick <= '0;
      level <= REG_RESET;
    end else begin
      tick <= next_tick;
      level <= next_level;
    end
  end

  assign busy = limit_on && (level != target);
endmodule // dacrm_slew

// ---- dacrm_top_checker.sv ----
/*
  Port assertions for the converter register map.
  Assumes binding to dacrm_top and a host that holds the strobe high
  for well over four clk_sys cycles.
*/
`timescale 1ns/1ps
module dacrm_top_checker
  import dacrm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic link_latch,
  input wire logic iout_fault_in,
  input wire logic over_temp_in,
  input wire logic serial_out_oe,
  input wire logic [15:0] dac_level,
  input wire logic output_on,
  input wire logic voltage_out_on,
  input wire logic current_out_on,
  input wire logic [2:0] range_select,
  input wire logic slew_limit_on,
  input wire logic [15:0] fault_status
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  a_volt_select: assert property (
    voltage_out_on == (output_on && range_select < RNG_UNDEF))
    else $error("voltage enable mismatch");
  a_curr_select: assert property (
    current_out_on == (output_on && range_select > RNG_UNDEF))
    else $error("current enable mismatch");
  a_status_reserved: assert property (
    fault_status[15:3] == 13'h0000)
    else $error("reserved status bits set");
  a_ifault_follow: assert property (
    $stable(iout_fault_in) [*4] |-> fault_status[ST_IFAULT] == iout_fault_in)
    else $error("current fault bit wrong");
  a_otemp_follow: assert property (
    $stable(over_temp_in) [*4] |-> fault_status[ST_OTEMP] == over_temp_in)
    else $error("over temperature bit wrong");
  a_oe_rise: assert property (
    $rose(serial_out_oe) |-> link_latch)
    else $error("serial out enabled without strobe");
  a_oe_fall: assert property (
    $fell(serial_out_oe) |-> link_latch)
    else $error("serial out disabled without strobe");
  a_ctrl_hold: assert property (
    $changed({output_on, slew_limit_on, range_select}) |-> link_latch)
    else $error("control changed outside a frame");
  a_slew_idle: assert property (
    !slew_limit_on [*3] |-> !fault_status[ST_SLEW])
    else $error("slewing while limiting is off");
  a_code_hold: assert property (
    $changed(dac_level) |->
      link_latch || fault_status[ST_SLEW] || $past(fault_status[ST_SLEW]))
    else $error("level changed without cause");
endmodule // dacrm_top_checker

bind dacrm_top dacrm_top_checker i_dacrm_top_checker (.clk_sys, .nrst,
  .link_latch, .iout_fault_in, .over_temp_in, .serial_out_oe, .dac_level,
  .output_on, .voltage_out_on, .current_out_on, .range_select,
  .slew_limit_on, .fault_status);

// ---- dacrm_host.sv ----
/*
  Host model: shifts frames msb first on the link and samples serial_out.
  Assumes the bench requests one frame at a time.
*/
`timescale 1ns/1ps
module dacrm_host (
  output logic link_clk,
  output logic link_data_in,
  output logic link_latch,
  input wire logic serial_out
);
  initial begin
    link_clk = 1'b0;
    link_data_in = 1'b0;
    link_latch = 1'b0;
  end

  // n rising edges, then the strobe; the clock stands still between frames
  task automatic send(input logic [23:0] f, input int n,
                      output logic [23:0] rx);
    rx = 24'h0;
    for (int i = 0; i < n; i++) begin
      link_data_in = f[23 - (i % 24)];
      #16 link_clk = 1'b1;
      rx = {rx[22:0], serial_out};
      #16 link_clk = 1'b0;
    end
    link_data_in = ~link_data_in;
    link_latch = 1'b1;
    #80 link_latch = 1'b0;
    #40;
  endtask
endmodule // dacrm_host

// ---- test_dac_register_map.sv ----
/*
  Self-checking bench for the converter register map.
  Assumes dacrm_top, dacrm_host and the bound checker are compiled.
*/
`timescale 1ns/1ps
module test_dac_register_map;
  import dacrm_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst, iout_fault_in, over_temp_in;
  logic link_clk, link_data_in, link_latch, serial_out, serial_out_oe;
  logic output_on, voltage_out_on, current_out_on, range_widen;
  logic external_resistor_select, clear_level_select, slew_limit_on;
  logic chain_mode_on;
  logic [2:0] range_select, slew_increment;
  logic [3:0] slew_update_rate;
  logic [15:0] dac_level, fault_status, d, v;
  logic [23:0] rx;
  int fail_count = 0;
  int checks_done = 0;
  wire logic [15:0] ctl_seen = {clear_level_select, range_widen,
    external_resistor_select, output_on, slew_update_rate, slew_increment,
    slew_limit_on, chain_mode_on, range_select};

  dacrm_top #(.CODE_BITS(16), .SLEW_UNIT(2)) i_dacrm_top (.clk_sys, .nrst,
    .link_clk, .link_data_in, .link_latch, .serial_out, .serial_out_oe,
    .iout_fault_in, .over_temp_in, .dac_level, .output_on, .voltage_out_on,
    .current_out_on, .range_select, .range_widen, .external_resistor_select,
    .clear_level_select, .slew_limit_on, .slew_update_rate, .slew_increment,
    .chain_mode_on, .fault_status);
  dacrm_host i_dacrm_host (.link_clk, .link_data_in, .link_latch,
    .serial_out);

  always #2.5 clk_sys = ~clk_sys;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] w);
    i_dacrm_host.send({a, w}, 24, rx);
  endtask

  // the request's strobe opens serial_out, the no-op frame shifts the word
  task automatic rd(input logic [1:0] s, output logic [15:0] w);
    wr(ADDR_READ, {14'h0, s});
    chk({15'h0, serial_out_oe}, 16'h0001);
    wr(ADDR_NOP, 16'h0000);
    w = rx[15:0];
    chk({15'h0, serial_out_oe}, 16'h0000);
  endtask

  task automatic stop_test;
    if (fail_count == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    nrst = 1'b0;
    iout_fault_in = 1'b0;
    over_temp_in = 1'b0;
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    chk(ctl_seen, 16'h0000);
    chk(fault_status, 16'h0000);
    wr(ADDR_CODE, 16'hBEEF);
    chk(dac_level, 16'hBEEF);
    rd(RD_CODE, d);
    chk(d, 16'hBEEF);
    for (int r = 0; r < 8; r++) begin
      v = 16'h7A40 | 16'(r);
      wr(ADDR_CTRL, v);
      chk(ctl_seen, v);
      chk({14'h0, voltage_out_on, current_out_on},
          {14'h0, r < 4, r > 4});
    end
    rd(RD_CTRL, d);
    chk(d, 16'h7A47);
    i_dacrm_host.send({ADDR_CTRL, 16'h8000}, 23, rx);
    i_dacrm_host.send({ADDR_CTRL, 16'h8000}, 25, rx);
    chk(ctl_seen, 16'h7A47);
    // a lone strobe must not decode the request again nor reopen the output
    wr(ADDR_READ, {14'h0, RD_CTRL});
    i_dacrm_host.send(24'h0, 0, rx);
    chk({15'h0, serial_out_oe}, 16'h0000);
    wr(ADDR_CTRL, 16'hC002);
    chk({14'h0, voltage_out_on, current_out_on}, 16'h0000);
    chk(ctl_seen, 16'hC002);
    wr(ADDR_CODE, 16'h0000);
    @(posedge clk_sys) iout_fault_in <= 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    chk(fault_status, 16'h0004);
    @(posedge clk_sys) iout_fault_in <= 1'b0;
    over_temp_in <= 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    chk(fault_status, 16'h0001);
    rd(RD_STATUS, d);
    chk(d, 16'h0001);
    @(posedge clk_sys) over_temp_in <= 1'b0;
    wr(ADDR_CTRL, 16'h0130);
    wr(ADDR_CODE, 16'h0040);
    chk({15'h0, fault_status[ST_SLEW]}, 16'h0001);
    for (int k = 0; k < 400 && fault_status[ST_SLEW] !== 1'b0; k++) begin
      @(posedge clk_sys);
      #1;
    end
    #1;
    chk({15'h0, fault_status[ST_SLEW]}, 16'h0000);
    chk(dac_level, 16'h0040);
    wr(ADDR_CTRL, 16'h0018);
    chk({15'h0, serial_out_oe}, 16'h0001);
    wr(ADDR_RST, 16'hFFFE);
    chk(ctl_seen, 16'h0018);
    wr(ADDR_RST, 16'h0001);
    chk(ctl_seen, 16'h0000);
    chk(dac_level, 16'h0000);
    chk({15'h0, serial_out_oe}, 16'h0000);
    stop_test();
  end
endmodule // test_dac_register_map
